// File: src/row_scan_pkg.sv
// Shared constants and carrier types for the row scan controller
package row_scan_pkg;
    localparam int ROW_LINES     = 8;
    localparam int COL_LINES     = 8;
    localparam int ROW_WIDTH     = 16;
    localparam int MATRIX_ROWS   = 64;
    localparam int HEALTH_WIDTH  = 8;
    localparam int MAINT_ROW     = 63;
    localparam int RETURN_CYCLES = 1;
    localparam logic [7:0] HEALTH_RESET    = 8'h00;
    localparam logic [15:0] PATTERN_RESET  = 16'h0000;

    typedef struct packed {
        logic [ROW_LINES-1:0] row_sel;
        logic [COL_LINES-1:0] col_sel;
    } order_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] pattern;
        logic [7:0]  health;
    } scan_return_t;
endpackage : row_scan_pkg

// File: src/order_check.sv
// Order decode and the access, single-core and interrogate checks
module order_check (
    input  wire row_scan_pkg::order_t order,      // Merged order from both buses
    input  wire logic                 enable,     // Dedicated enable lead
    input  wire logic [63:0]          core_sw,    // Core switched feedback
    output logic [5:0]                row_index,  // Selected row
    output logic                      access_ok,  // Enable met an address pulse
    output logic                      single_ok,  // At most one core chosen
    output logic                      interr_ok   // A core switched
);
    logic [63:0] chosen;
    logic [3:0]  row_count;
    logic [3:0]  col_count;
    logic [2:0]  row_bin;
    logic [2:0]  col_bin;

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_core
            assign chosen[g] = order.row_sel[g/8] & order.col_sel[g%8];
        end
    endgenerate

    always_comb begin
        row_count = 4'h0;
        col_count = 4'h0;
        row_bin   = 3'h0;
        col_bin   = 3'h0;
        for (int i = 0; i < 8; i++) begin
            row_count = row_count + {3'h0, order.row_sel[i]};
            col_count = col_count + {3'h0, order.col_sel[i]};
            if (order.row_sel[i]) row_bin = 3'(i);
            if (order.col_sel[i]) col_bin = 3'(i);
        end
    end

    assign row_index = {row_bin, col_bin};
    assign access_ok = enable & ((|order.row_sel) | (|order.col_sel));
    assign single_ok = (row_count <= 4'h1) & (col_count <= 4'h1);
    assign interr_ok = |(chosen & core_sw);
endmodule : order_check

// File: src/row_scan_controller.sv
// Row scan controller: takes enabled orders and returns pattern plus health code
// Behaviour
// - Act only on orders with own enable
// - Two one-hot eight-line pulses pick core
// - Accept orders on either peripheral bus
// - 64 rows of 16, one row per order
// - One row reserved for self maintenance
// - Same 16-bit pattern on both returns
// - Saturated element gives no pulse bit
// - Check enable coincides with address pulse
// - Check at most one core selected
// - Check some core actually switched
// - Health code together with row pattern
// - Unique three-of-eight health code
// - Health code on separate eight lines
module row_scan_controller #(
    parameter logic [7:0] HEALTH_ID = 8'h07  // Arbitrary unit code, three bits set
) (
    input  wire logic                  clk,          // 25 MHz clock
    input  wire logic                  reset_n,      // Synchronous reset, active low
    input  wire row_scan_pkg::order_t  order_a,      // Peripheral bus A order
    input  wire row_scan_pkg::order_t  order_b,      // Peripheral bus B order
    input  wire logic                  enable,       // Dedicated enable pulse
    input  wire logic [1023:0]         sense_sat,    // Element saturated, per point
    input  wire logic [63:0]           core_sw,      // Core switched feedback
    output logic [15:0]                return_a,     // Return bus of controller A
    output logic [15:0]                return_b,     // Return bus of controller B
    output logic [7:0]                 health_code,  // Health code bus
    output logic                       return_valid, // Return buses hold a reply
    output logic [15:0]                maint_pattern // Reserved maintenance row
);
    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    localparam int         ROW_BITS   = row_scan_pkg::ROW_WIDTH;
    localparam logic [5:0] MAINT_IDX  = 6'(row_scan_pkg::MAINT_ROW);
    // Reply stands this many cycles plus one; one with the default
    localparam logic [3:0] HOLD_LAST  = 4'(row_scan_pkg::RETURN_CYCLES - 1);
    // Failing unit drops its lowest code bit; the rest still names the unit
    localparam logic [7:0] HEALTH_BAD = HEALTH_ID & (HEALTH_ID - 8'h01);

    // Value the return lines fall back to between replies
    localparam row_scan_pkg::scan_return_t REPLY_IDLE = '{
        valid:   1'b0,
        pattern: row_scan_pkg::PATTERN_RESET,
        health:  row_scan_pkg::HEALTH_RESET
    };

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDLE  = 2'b01,
        REPLY = 2'b10
    } state_t;

    state_t                     state_reg;
    state_t                     state_next;
    logic [3:0]                 hold_reg;
    logic [3:0]                 hold_next;
    row_scan_pkg::scan_return_t reply_a_reg;
    row_scan_pkg::scan_return_t reply_a_next;
    logic [15:0]                pattern_b_reg;
    logic [15:0]                pattern_b_next;
    logic [15:0]                maint_reg;
    logic [15:0]                maint_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    row_scan_pkg::order_t       order;
    row_scan_pkg::scan_return_t reply_fresh;
    logic [5:0]                 row_index;
    logic                       access_ok;
    logic                       single_ok;
    logic                       interr_ok;
    logic [2:0]                 check_bits;
    logic                       all_ok;
    logic                       in_idle;
    logic                       in_reply;
    logic                       take;
    logic                       leaving;
    logic                       maint_hit;
    logic [15:0]                row_pattern;
    logic [15:0]                row_pattern_b;
    logic [15:0]                maint_row;
    logic [7:0]                 health_val;

    // Buses are idle-low, so OR merges whichever one carries the order
    assign order = order_a | order_b;

    order_check u_check (
        .order     (order),
        .enable    (enable),
        .core_sw   (core_sw),
        .row_index (row_index),
        .access_ok (access_ok),
        .single_ok (single_ok),
        .interr_ok (interr_ok)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // All three must pass in the take cycle for a full code
    assign check_bits = {access_ok, single_ok, interr_ok};
    assign all_ok     = &check_bits;

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    assign in_idle   = (state_reg == IDLE);
    assign in_reply  = (state_reg == REPLY);
    // Without enable no order is ever taken, the unit stays silent
    assign take      = enable & in_idle;
    // Enable seen during the reply is dropped; the processor must resend
    assign leaving   = in_reply & (hold_reg == HOLD_LAST);
    assign maint_hit = take & (row_index == MAINT_IDX);

    always_comb begin
        case (state_reg)
            IDLE:    state_next = take ? REPLY : IDLE;
            REPLY:   state_next = leaving ? IDLE : REPLY;
            default: state_next = IDLE;
        endcase
    end

    assign hold_next = (in_reply & ~leaving) ? hold_reg + 4'h1 : 4'h0;

    // ------------------------------------------------------------
    // Row readout
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_bit
            // Pulse only when element not saturated
            assign row_pattern[b]   = ~sense_sat[row_index*ROW_BITS + b];
            assign row_pattern_b[b] = ~sense_sat[row_index*ROW_BITS + b];
            assign maint_row[b]     = ~sense_sat[row_scan_pkg::MAINT_ROW*ROW_BITS + b];
        end
    endgenerate

    // A multi-core select reads an ambiguous row; only health flags it
    assign health_val = all_ok ? HEALTH_ID : HEALTH_BAD;

    // ------------------------------------------------------------
    // Next reply
    // ------------------------------------------------------------
    always_comb begin
        reply_fresh         = REPLY_IDLE;
        reply_fresh.valid   = 1'b1;
        reply_fresh.pattern = row_pattern;
        reply_fresh.health  = health_val;
    end

    assign reply_a_next = take    ? reply_fresh :
                          leaving ? REPLY_IDLE  :
                                    reply_a_reg;

    // Second controller keeps its own copy so the processor can match them
    assign pattern_b_next = take    ? row_pattern_b :
                            leaving ? row_scan_pkg::PATTERN_RESET :
                                      pattern_b_reg;

    assign maint_next = maint_hit ? maint_row : maint_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset: every output is zero from the first edge with reset_n low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hold_reg <= 4'h0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reply_a_reg <= REPLY_IDLE;
        end else begin
            reply_a_reg <= reply_a_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pattern_b_reg <= row_scan_pkg::PATTERN_RESET;
        end else begin
            pattern_b_reg <= pattern_b_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            maint_reg <= row_scan_pkg::PATTERN_RESET;
        end else begin
            maint_reg <= maint_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign return_a      = reply_a_reg.pattern;
    assign return_b      = pattern_b_reg;
    assign health_code   = reply_a_reg.health;
    assign return_valid  = reply_a_reg.valid;
    assign maint_pattern = maint_reg;
endmodule : row_scan_controller

// File: verification/row_scan_properties.sv
// Checker of reply timing and health code
module row_scan_properties #(parameter logic [7:0] HEALTH_ID = 8'h07) (
    input wire logic                 clk,          // Clock
    input wire logic                 reset_n,      // Reset
    input wire row_scan_pkg::order_t order_a,      // Bus A
    input wire row_scan_pkg::order_t order_b,      // Bus B
    input wire logic                 enable,       // Enable
    input wire logic [63:0]          core_sw,      // Cores
    input wire logic [15:0]          return_a,     // Return A
    input wire logic [15:0]          return_b,     // Return B
    input wire logic [7:0]           health_code,  // Health
    input wire logic                 return_valid  // Reply
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Checks
    // ------
    wire logic [7:0] rs = order_a.row_sel | order_b.row_sel;
    wire logic [7:0] cs = order_a.col_sel | order_b.col_sel;
    // Core at the chosen row and column that reports a switch
    wire logic [63:0] hit;
    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_hit
            assign hit[g] = rs[g/8] & cs[g%8] & core_sw[g];
        end
    endgenerate
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Only fresh enable pulses are tracked; a held one may retake later
    sequence take; enable && !return_valid && !$past(enable); endsequence
    AST_TAKE: assert property (take |=> return_valid)
        else $error("no reply");
    AST_IGNORE: assert property (!enable |=> !return_valid)
        else $error("stray reply");
    AST_PAIR: assert property (return_valid |-> return_a == return_b)
        else $error("buses differ");
    AST_FREE: assert property (!return_valid |-> (return_a | health_code) == 0)
        else $error("not released");
    AST_CODE: assert property (return_valid |-> ((health_code & ~HEALTH_ID) == 8'h00) && ($countones(health_code) >= 2))
        else $error("bad code");
    AST_OK: assert property (take ##0 ($onehot(rs) && $onehot(cs) && hit != 64'h0)
        |=> health_code == HEALTH_ID) else $error("healthy missing");
    AST_MULTI: assert property (take ##0 ($countones(rs) > 1)
        |=> health_code != HEALTH_ID) else $error("multi core");
    AST_NOSW: assert property (take ##0 (core_sw == 0)
        |=> health_code != HEALTH_ID) else $error("no switch");
endmodule : row_scan_properties
bind row_scan_controller row_scan_properties #(.HEALTH_ID(HEALTH_ID)) u_props (
    .clk          (clk),
    .reset_n      (reset_n),
    .order_a      (order_a),
    .order_b      (order_b),
    .enable       (enable),
    .core_sw      (core_sw),
    .return_a     (return_a),
    .return_b     (return_b),
    .health_code  (health_code),
    .return_valid (return_valid)
);

// File: verification/cpu_model.sv
// Central processor model: sends orders, judges replies
module cpu_model #(parameter logic [7:0] HEALTH_ID = 8'h07) (
    input  wire logic [15:0]    return_a,     // Return A
    input  wire logic [15:0]    return_b,     // Return B
    input  wire logic [7:0]     health_code,  // Health
    input  wire logic           return_valid, // Reply
    input  wire logic           clk,          // Clock
    output row_scan_pkg::order_t order_a,     // Bus A
    output row_scan_pkg::order_t order_b,     // Bus B
    output logic                enable,       // Enable
    output logic                mismatch,     // Buses disagreed
    output logic                fault         // Code bit missing
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Orders
    // ------
    initial {order_a, order_b, enable} = '0;
    task automatic send(input logic bus, input logic en, input logic [15:0] ord);
        @(negedge clk);
        if (bus) order_b = ord; else order_a = ord;
        enable = en;
        @(negedge clk);
        {order_a, order_b, enable} = '0;
    endtask : send
    always @(posedge clk) if (return_valid) begin
        mismatch <= return_a !== return_b;
        fault    <= health_code !== HEALTH_ID;
    end
endmodule : cpu_model

// File: verification/testbench.sv
// Self-checking bench for the row scan controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------
    // Scenarios
    // ---------
    localparam logic [7:0] HID = 8'h07; // Arbitrary unit code
    logic clk = 0, reset_n = 0, enable, mismatch, fault, return_valid;
    row_scan_pkg::order_t order_a, order_b;
    logic [1023:0] sense_sat;
    logic [63:0] core_sw = '0;
    logic [15:0] return_a, return_b, maint_pattern;
    logic [7:0] health_code;
    int n_errors = 0, n_checks = 0;
    always #20 clk = ~clk;
    row_scan_controller #(.HEALTH_ID(HID)) DUT (.*);
    cpu_model #(.HEALTH_ID(HID)) cpu (.*);
    task automatic chk(input string what, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic scan(input logic bus, en, input logic [15:0] ord, input logic [63:0] core);
        @(negedge clk) core_sw = core;
        cpu.send(bus, en, ord);
    endtask : scan
    task automatic t_rows;
        int r, c, k;
        for (int i = 0; i < 9; i++) begin
            r = (i == 8) ? 7 : i;
            c = (i == 8) ? 7 : 7 - i;
            k = r * 8 + c;
            scan(i[0], 1, {8'h01 << r, 8'h01 << c}, 64'h1 << k);
            chk("valid", 16'(return_valid), 16'h0001);
            chk("return_a", return_a, ~(16'(k) * 16'h0203));
            chk("return_b", return_b, ~(16'(k) * 16'h0203));
            chk("health", 16'(health_code), 16'(HID));
            @(posedge clk) #1;
            chk("cpu", 16'({mismatch, fault}), 16'h0);
            chk("free", return_a | return_b | 16'(health_code), 16'h0);
        end
        chk("maint", maint_pattern, ~(16'd63 * 16'h0203));
    endtask : t_rows
    task automatic t_faults;
        logic [15:0] ord [3] = '{16'h0301, 16'h0101, 16'h0000};
        logic [63:0] cor [3] = '{64'h1, 64'h0, 64'h1};
        scan(0, 0, 16'h0101, 64'h1);
        chk("ignored", 16'(return_valid), 16'h0);
        for (int i = 0; i < 3; i++) begin
            scan(1, 1, ord[i], cor[i]);
            chk("bad", 16'(health_code), 16'(HID & (HID - 8'h01)));
            @(posedge clk) #1;
            chk("fault", 16'(fault), 16'h0001);
        end
    endtask : t_faults
    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        for (int k = 0; k < 64; k++) sense_sat[k*16 +: 16] = 16'(k) * 16'h0203;
        repeat (8) @(negedge clk);
        reset_n = 1;
        t_rows();
        t_faults();
        print_verdict();
    end
    initial begin
        #10000;
        n_errors++;
        print_verdict();
    end
endmodule : testbench
